// ===== hdl/bst_pkg.sv
package bst_pkg;
  // ************************************************************
  // Instruction register
  // ************************************************************
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h055;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h059;
  localparam logic [IR_W-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] OP_CLAMP = 10'h00a;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  // Programming opcodes: top two bits 10, so bypass is never one
  localparam logic [1:0] OP_PROG_PREFIX = 2'h2;
  // ************************************************************
  // Register widths and defaults
  // ************************************************************
  localparam int ID_W = 32;
  localparam int PROG_W = 16;
  // Arbitrary identification value, not a real part code
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_1001;
  localparam logic [ID_W-1:0] USER_DEFAULT = 32'hffff_ffff;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_link_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } bst_edge_t;
endpackage

// ===== hdl/bst_port.sv
`timescale 1ns/10ps
`default_nettype none
module bst_port
  import bst_pkg::*;
#(
  parameter int NPIN = 8,
  parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Test port pins, sampled as asynchronous inputs
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo_out,
  output logic tdo_oe,
  // Port enable; low hands the test pins to user logic
  input wire logic port_enable,
  output logic [2:0] user_pins_in,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  // Core and pad side
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] pad_in,
  output logic [NPIN-1:0] pad_out,
  // Programming side
  input wire logic [ID_W-1:0] user_code,
  output logic prog_active,
  output logic [IR_W-1:0] prog_opcode,
  output logic [PROG_W-1:0] prog_data,
  output logic prog_strobe
);
  // ************************************************************
  // Synchronisers and edge finding
  // ************************************************************
  bst_link_t sync1_reg, sync2_reg, last_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      last_reg <= '0;
    end else begin
      sync1_reg <= '{tck_pin, tms_pin, tdi_pin};
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end
  bst_edge_t edge_w;
  assign edge_w.rise = port_enable & sync2_reg.tck & ~last_reg.tck;
  assign edge_w.fall = port_enable & ~sync2_reg.tck & last_reg.tck;
  // Raw pins to user logic when the port is off; pins are the same wires
  assign user_pins_in = port_enable ? 3'h0 : {tck_pin, tms_pin, tdi_pin};

  // ************************************************************
  // Controller
  // ************************************************************
  bst_state_t state_reg, state_next;
  wire tms_w = sync2_reg.tms;
  always_comb begin
    unique case (state_reg)
      ST_RESET: state_next = tms_w ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms_w ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_w ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_w ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms_w ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms_w ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms_w ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms_w ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_next = tms_w ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_w ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_w ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms_w ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms_w ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms_w ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms_w ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_next = tms_w ? ST_SEL_DR : ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_RESET;
    end else if (!port_enable) begin
      state_reg <= ST_RESET;
    end else if (edge_w.rise) begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Instruction decode
  // ************************************************************
  logic [IR_W-1:0] ir_sh_reg, ir_reg;
  wire is_extest = ir_reg == OP_EXTEST;
  wire is_sample = ir_reg == OP_SAMPLE;
  wire is_idcode = ir_reg == OP_IDCODE;
  wire is_user = ir_reg == OP_USERCODE;
  wire is_clamp = ir_reg == OP_CLAMP;
  wire is_prog = (ir_reg[IR_W-1 -: 2] == OP_PROG_PREFIX);
  wire sel_bsr = is_extest | is_sample;
  wire sel_id = is_idcode | is_user;
  wire sel_bypass = ~(sel_bsr | sel_id | is_prog);
  wire in_cap_dr = edge_w.rise & (state_reg == ST_CAP_DR);
  wire in_sh_dr = edge_w.rise & (state_reg == ST_SHIFT_DR);
  wire in_upd_dr = edge_w.rise & (state_reg == ST_UPD_DR);
  wire tdi_w = sync2_reg.tdi;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ir_sh_reg <= '0;
      ir_reg <= OP_IDCODE;
    end else if (!port_enable || (edge_w.rise && state_reg == ST_RESET)) begin
      ir_reg <= OP_IDCODE;
    end else if (edge_w.rise) begin
      if (state_reg == ST_CAP_IR) begin
        ir_sh_reg <= IR_CAPTURE;
      end else if (state_reg == ST_SHIFT_IR) begin
        ir_sh_reg <= {tdi_w, ir_sh_reg[IR_W-1:1]};
      end else if (state_reg == ST_UPD_IR) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // ************************************************************
  // Data registers
  // ************************************************************
  logic bypass_reg;
  logic [ID_W-1:0] id_sh_reg;
  logic [NPIN-1:0] bsr_sh_reg, bsr_upd_reg;
  logic [PROG_W-1:0] prog_sh_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bypass_reg <= 1'b0;
      id_sh_reg <= '0;
      bsr_sh_reg <= '0;
      prog_sh_reg <= '0;
    end else if (in_cap_dr) begin
      bypass_reg <= 1'b0;
      id_sh_reg <= is_user ? user_code : ID_VALUE;
      bsr_sh_reg <= pad_in;
    end else if (in_sh_dr) begin
      bypass_reg <= tdi_w;
      id_sh_reg <= {tdi_w, id_sh_reg[ID_W-1:1]};
      bsr_sh_reg <= {tdi_w, bsr_sh_reg[NPIN-1:1]};
      prog_sh_reg <= {tdi_w, prog_sh_reg[PROG_W-1:1]};
    end
  end
  // Update stage holds the pattern so shifting never glitches the pads
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bsr_upd_reg <= '0;
    end else if (in_upd_dr && sel_bsr) begin
      bsr_upd_reg <= bsr_sh_reg;
    end
  end
  wire drive_test = is_extest | is_clamp;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pad_out <= '0;
      prog_data <= '0;
      prog_opcode <= '0;
      prog_strobe <= 1'b0;
    end else begin
      pad_out <= drive_test ? bsr_upd_reg : core_out;
      prog_strobe <= in_upd_dr & is_prog;
      if (in_upd_dr && is_prog) begin
        prog_data <= prog_sh_reg;
        prog_opcode <= ir_reg;
      end
    end
  end
  assign prog_active = is_prog & port_enable;

  // ************************************************************
  // Serial output on falling edge
  // ************************************************************
  logic tdo_reg, tdo_oe_reg;
  wire sh_dr = state_reg == ST_SHIFT_DR;
  wire sh_ir = state_reg == ST_SHIFT_IR;
  wire dr_bit = sel_bypass ? bypass_reg : sel_id ? id_sh_reg[0] :
    is_prog ? prog_sh_reg[0] : bsr_sh_reg[0];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (!port_enable) begin
      tdo_oe_reg <= 1'b0;
    end else if (edge_w.fall) begin
      tdo_reg <= sh_ir ? ir_sh_reg[0] : dr_bit;
      tdo_oe_reg <= sh_ir | sh_dr;
    end
  end
  assign tdo_out = port_enable ? tdo_reg : user_tdo_out;
  assign tdo_oe = port_enable ? tdo_oe_reg : user_tdo_oe;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_reset_ir: assert property (@(posedge ref_clk) disable iff (reset)
    (edge_w.rise && state_reg == ST_RESET) |=> ir_reg == OP_IDCODE)
    else $error("instruction not reset to identification");
  chk_fsm_step: assert property (@(posedge ref_clk) disable iff (reset)
    (port_enable && !edge_w.rise) |=> $stable(state_reg))
    else $error("controller moved without a rising test clock");
  chk_oe_shift: assert property (@(posedge ref_clk) disable iff (reset)
    (port_enable && edge_w.fall && !(sh_dr || sh_ir)) |=> !tdo_oe)
    else $error("data out enabled outside shift");
  chk_clamp_pins: assert property (@(posedge ref_clk) disable iff (reset)
    (is_clamp && $stable(is_clamp)) |=> pad_out == $past(bsr_upd_reg))
    else $error("clamp pins not from scan register");
  chk_sample_pass: assert property (@(posedge ref_clk) disable iff (reset)
    is_sample |=> pad_out == $past(core_out))
    else $error("sample disturbed pins");
  chk_extest_cap: assert property (@(posedge ref_clk) disable iff (reset)
    (in_cap_dr && is_extest) |=> bsr_sh_reg == $past(pad_in))
    else $error("external test capture wrong");
  chk_bypass_cap: assert property (@(posedge ref_clk) disable iff (reset)
    in_cap_dr |=> !bypass_reg)
    else $error("bypass capture not zero");
  chk_user_cap: assert property (@(posedge ref_clk) disable iff (reset)
    (in_cap_dr && is_user) |=> id_sh_reg == $past(user_code))
    else $error("user code not captured");
  chk_port_off: assert property (@(posedge ref_clk) disable iff (reset)
    !port_enable |-> (tdo_oe == user_tdo_oe))
    else $error("test pin not handed to user");
  chk_off_reset: assert property (@(posedge ref_clk) disable iff (reset)
    !port_enable |=> (state_reg == ST_RESET) && (ir_reg == OP_IDCODE))
    else $error("disabled port left controller out of reset");
  chk_prog_strobe: assert property (@(posedge ref_clk) disable iff (reset)
    prog_strobe |-> $past(is_prog))
    else $error("programming strobe without programming opcode");
  cov_shift_dr: cover property (@(posedge ref_clk) in_sh_dr && sel_id);
  cov_bypass: cover property (@(posedge ref_clk) in_sh_dr && sel_bypass);
  cov_extest: cover property (@(posedge ref_clk) is_extest && in_upd_dr);
  cov_prog: cover property (@(posedge ref_clk) prog_strobe);
endmodule
`default_nettype wire

// ===== tb/bst_host.sv
`timescale 1ns/10ps
`default_nettype none
module bst_host
  import bst_pkg::*;
(
  // Link toward the test port
  output var bst_link_t link,
  input wire logic tdo
);
  // Clock stands low between frames
  initial link = '0;
  // ************************************************************
  // One 125 ns link clock; tms and tdi change only after the fall
  // ************************************************************
  task automatic step(input logic tms, input logic tdi, output logic seen);
    link.tms = tms;
    link.tdi = tdi;
    #62.5 link.tck = 1'b1;
    seen = tdo;
    #62.5 link.tck = 1'b0;
  endtask
  task automatic go_reset();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  // Instruction load from idle, back to idle
  task automatic load_ir(input logic [IR_W-1:0] op, output logic [IR_W-1:0] cap);
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < IR_W; i++) begin
      step(i == IR_W - 1, op[i], cap[i]);
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  // Data scan of n bits, lsb first
  task automatic shift_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

// ===== tb/bst_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bst_port_tb;
  import bst_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  bst_link_t link;
  logic tdo_out, tdo_oe, port_enable, user_tdo_out, user_tdo_oe, prog_active, prog_strobe;
  logic [2:0] user_pins_in;
  logic [7:0] core_out, pad_in, pad_out;
  logic [ID_W-1:0] user_code;
  logic [IR_W-1:0] prog_opcode, ir_seen;
  logic [PROG_W-1:0] prog_data;
  logic [63:0] dout;
  int bad_count = 0, checks = 0, cycles = 0, strobes = 0;
  // Released tdo floats high through the board pull-up
  wire logic tdo_wire = tdo_oe ? tdo_out : 1'b1;

  always #5 ref_clk = ~ref_clk;

  bst_port bst_port_inst (.ref_clk(ref_clk), .reset(reset), .tck_pin(link.tck),
    .tms_pin(link.tms), .tdi_pin(link.tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .port_enable(port_enable), .user_pins_in(user_pins_in), .user_tdo_out(user_tdo_out),
    .user_tdo_oe(user_tdo_oe), .core_out(core_out), .pad_in(pad_in), .pad_out(pad_out),
    .user_code(user_code), .prog_active(prog_active), .prog_opcode(prog_opcode),
    .prog_data(prog_data), .prog_strobe(prog_strobe));
  bst_host bst_host_inst (.link(link), .tdo(tdo_wire));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Whole run needs about 4700 cycles
  // Strobe is counted away from its launching edge
  always @(negedge ref_clk) begin
    if (prog_strobe === 1'b1) strobes++;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic t_idcode();
    bst_host_inst.go_reset();
    check(tdo_oe, 1'b0, "tdo driven in idle");
    bst_host_inst.load_ir(OP_IDCODE, ir_seen);
    check(ir_seen, IR_CAPTURE, "ir capture");
    bst_host_inst.shift_dr(32, 64'h0, dout);
    check(dout[31:0], ID_DEFAULT, "id value");
  endtask
  // Unknown opcode must behave like bypass too
  task automatic t_bypass();
    logic [IR_W-1:0] ops [2] = '{OP_BYPASS, 10'h1f0};
    for (int k = 0; k < 2; k++) begin
      bst_host_inst.load_ir(ops[k], ir_seen);
      bst_host_inst.shift_dr(9, 64'h1b5, dout);
      check(dout[8:0], 9'h16a, "bypass path");
    end
  endtask
  task automatic t_usercode();
    bst_host_inst.load_ir(OP_USERCODE, ir_seen);
    bst_host_inst.shift_dr(32, 64'h0, dout);
    check(dout[31:0], 32'h5a3c_96e1, "user code");
  endtask
  task automatic t_boundary();
    bst_host_inst.load_ir(OP_SAMPLE, ir_seen);
    bst_host_inst.shift_dr(8, 64'h3c, dout);
    check(dout[7:0], 8'hb2, "sample capture");
    check(pad_out, 8'h4d, "sample disturbed pads");
    bst_host_inst.load_ir(OP_EXTEST, ir_seen);
    check(pad_out, 8'h3c, "extest drive");
    @(negedge ref_clk) pad_in = 8'h71;
    bst_host_inst.shift_dr(8, 64'h3c, dout);
    check(dout[7:0], 8'h71, "extest capture");
    bst_host_inst.load_ir(OP_CLAMP, ir_seen);
    check(pad_out, 8'h3c, "clamp drive");
    bst_host_inst.shift_dr(2, 64'h1, dout);
    check(dout[1:0], 2'b10, "clamp path");
    bst_host_inst.load_ir(OP_SAMPLE, ir_seen);
    check(pad_out, 8'h4d, "pads back to core");
  endtask
  task automatic t_prog();
    bst_host_inst.load_ir(10'h2a5, ir_seen);
    check(prog_active, 1'b1, "prog active");
    strobes = 0;
    bst_host_inst.shift_dr(16, 64'hbeef, dout);
    check(prog_data, 16'hbeef, "prog data");
    check(prog_opcode, 10'h2a5, "prog opcode");
    check(strobes, 1, "prog strobe count");
  endtask
  // Clock edges while disabled must be ignored, controller restarts at reset
  task automatic t_disable();
    logic d;
    bst_host_inst.load_ir(OP_USERCODE, ir_seen);
    @(negedge ref_clk);
    port_enable = 1'b0;
    user_tdo_out = 1'b1;
    user_tdo_oe = 1'b1;
    bst_host_inst.link = 3'b110;
    #20 check(user_pins_in, 3'b110, "user pins");
    check({tdo_oe, tdo_out}, 2'b11, "user tdo");
    bst_host_inst.load_ir(OP_BYPASS, ir_seen);
    @(negedge ref_clk) port_enable = 1'b1;
    // No reset sequence: a taken bypass load would show in the scan below
    bst_host_inst.step(1'b0, 1'b0, d);
    bst_host_inst.shift_dr(32, 64'h0, dout);
    check(dout[31:0], ID_DEFAULT, "disabled port took edges");
  endtask

  initial begin
    port_enable = 1'b1;
    user_tdo_out = 1'b0;
    user_tdo_oe = 1'b0;
    core_out = 8'h4d;
    pad_in = 8'hb2;
    user_code = 32'h5a3c_96e1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    t_idcode();
    t_bypass();
    t_usercode();
    t_boundary();
    t_prog();
    t_disable();
    test_done();
  end
endmodule
`default_nettype wire
